//--- core/bpss_pkg.sv
// package for the branch and return-address sequencer: constants, codes, request struct
// assumes a single core clock and a classic wishbone register bus
package bpss_pkg;
  // ==========================================================
  // widths and stack geometry
  localparam int          ADDR_W      = 24;
  localparam int          PTR_W       = 5;
  localparam logic [4:0]  STK_DEPTH   = 5'h14;
  localparam logic [4:0]  STK_ALMOST  = 5'h13;
  localparam logic [4:0]  PTR_EMPTY   = 5'h00;
  localparam logic [4:0]  PTR_OVFL    = 5'h1F;
  localparam logic [4:0]  PTR_ONE     = 5'h01;
  localparam logic [4:0]  COND_ALWAYS = 5'h1F;
  localparam logic [23:0] DELAY_RET   = 24'h000003;
  localparam logic [1:0]  SHADOW_LEN  = 2'h2;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0]  REG_TOP     = 8'h00;
  localparam logic [7:0]  REG_PTR     = 8'h04;
  localparam logic [7:0]  REG_STICKY  = 8'h08;
  localparam logic [7:0]  REG_MASK    = 8'h0C;
  // ==========================================================
  // sticky_status_reg field positions
  localparam int          STK_EMPTY_B = 0;
  localparam int          STK_FULL_B  = 1;
  localparam int          STK_OVFL_B  = 2;
  localparam int          LOOP_OVF_B  = 3;
  localparam int          CNT_OVF_B   = 4;
  localparam int          STAT_OVF_B  = 5;
  localparam int          MASK_STK_B  = 0;
  // ==========================================================
  // branch kinds and target sources
  typedef enum logic [1:0] {
    BPSS_JUMP = 2'b00,
    BPSS_CALL = 2'b01,
    BPSS_RTS  = 2'b10,
    BPSS_RTI  = 2'b11
  } bpss_kind_t;
  typedef enum logic [1:0] {
    BPSS_DIRECT   = 2'b00,
    BPSS_INDIRECT = 2'b01,
    BPSS_RELATIVE = 2'b10
  } bpss_src_t;
  typedef struct packed {
    logic        valid;
    bpss_kind_t  kind;
    bpss_src_t   src;
    logic        hasCond;
    logic [4:0]  condCode;
    logic        delayed;
    logic        loopAbort;
    logic [23:0] imm;
    logic [23:0] execAddr;
    logic [23:0] decodeAddr;
  } bpss_branch_t;
  typedef struct packed {
    logic loopPush;
    logic loopFull;
    logic cntPush;
    logic cntFull;
    logic statPush;
    logic statFull;
  } bpss_stacks_t;
endpackage : bpss_pkg

//--- core/bpss_sequencer.sv
// branch target selection, return-address stack, and its wishbone register view
// assumes the pipeline presents one execute-stage request per cycle on mclk
//
// Design decisions made here: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ns
// Notes on behaviour
// - code 31: loop false, conditional true
// - call pushes return address, jump pushes nothing
// - return fetches from stack top and pops
// - interrupt_return pops status only after interrupt push
// - branch taken only when condition true
// - indirect target comes from second_address_generator
// - direct target is 24-bit immediate field
// - relative target is immediate plus program counter
// - nondelayed branch squashes fetch and decode stages
// - nondelayed call pushes decode-stage address
// - delayed branch runs two more; pushes plus three
// - loop_abort jump pops both stacks once
// - interrupt during delayed branch waits three instructions
// - stack and pointer reflect delayed push immediately
// - stack holds twenty 24-bit entries
// - pop on both returns and loop termination
// - full, empty, overflow kept in sticky_status_reg
// - maskable interrupt at nineteen occupied entries
// - other stacks flag overflow on full push
// - pointer reads 0, 1..20, or 31; a pointer register write can load any 5-bit value, 21..30 included
// - pointer write applies one cycle later
// - pointer write ignored while overflowed
// - loop start pushes the top-of-loop address
module bpss_sequencer (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire bpss_pkg::bpss_branch_t br,
  input  wire logic [23:0]            dagAddr,
  input  wire logic [30:0]            condFlags,
  input  wire logic                   loopTestValid,
  input  wire logic [4:0]             loopCondCode,
  input  wire logic                   inLoop,
  input  wire logic                   loopStartValid,
  input  wire logic [23:0]            loopTopAddr,
  input  wire logic                   statusFromIrq,
  input  wire logic                   irqRequest,
  input  wire logic                   irqEntry,
  input  wire logic [23:0]            irqRetAddr,
  input  wire bpss_pkg::bpss_stacks_t stacks,
  input  wire logic                   wb_cyc_i,
  input  wire logic                   wb_stb_i,
  input  wire logic                   wb_we_i,
  input  wire logic [7:0]             wb_adr_i,
  input  wire logic [3:0]             wb_sel_i,
  input  wire logic [31:0]            wb_dat_i,
  output logic      [31:0]            wb_dat_o,
  output logic                        wb_ack_o,
  output logic                        redirect,
  output logic      [23:0]            redirectAddr,
  output logic                        squashFetch,
  output logic                        squashDecode,
  output logic                        statusPop,
  output logic                        loopStackPop,
  output logic                        loopExit,
  output logic                        irqService,
  output logic                        stackIrq,
  output logic                        loopOvfIrq,
  output logic                        cntOvfIrq,
  output logic                        statOvfIrq
);
  // ==========================================================
  // condition evaluation
  function automatic logic condTrue(input logic [4:0] code, input logic [30:0] f,
                                    input logic forLoop);
    if (code == bpss_pkg::COND_ALWAYS)
      condTrue = !forLoop;
    else
      condTrue = f[code];
  endfunction : condTrue

  // ==========================================================
  // state
  logic [23:0] stack_q [0:19];
  logic [4:0]  ptr_q;
  logic [4:0]  ptrWr_q;
  logic        ptrWrPend_q;
  logic [1:0]  shadow_q;
  logic        irqPend_q;
  logic [2:0]  ovf_q;
  logic        mask_q;
  logic        ack_q;
  logic [31:0] rdat_q;
  logic        redirect_q;
  logic [23:0] redirectAddr_q;
  logic        squash_q;
  logic        statusPop_q;
  logic        loopPop_q;
  logic        loopExit_q;
  logic        irqService_q;

  // ==========================================================
  // branch decode
  wire         isCall     = br.kind == bpss_pkg::BPSS_CALL;
  wire         isRet      = br.kind == bpss_pkg::BPSS_RTS || br.kind == bpss_pkg::BPSS_RTI;
  wire         brCond     = !br.hasCond || condTrue(br.condCode, condFlags, 1'b0);
  wire         brTaken    = br.valid && brCond;
  wire         callTaken  = brTaken && isCall;
  wire         retTaken   = brTaken && isRet;
  wire         abortTaken = brTaken && br.kind == bpss_pkg::BPSS_JUMP && br.loopAbort && inLoop;
  wire         loopEnd    = loopTestValid && condTrue(loopCondCode, condFlags, 1'b1);
  wire         overflowed = ptr_q == bpss_pkg::PTR_OVFL;
  wire         empty      = ptr_q == bpss_pkg::PTR_EMPTY;
  wire         full       = ptr_q == bpss_pkg::STK_DEPTH;
  wire [4:0]   topIdx     = ptr_q - bpss_pkg::PTR_ONE;
  wire [23:0]  topVal     = (empty || overflowed) ? '0 : stack_q[topIdx];
  wire [23:0]  relTarget  = br.execAddr + br.imm;
  wire [23:0]  callTarget = (br.src == bpss_pkg::BPSS_INDIRECT) ? dagAddr :
                            (br.src == bpss_pkg::BPSS_RELATIVE) ? relTarget :
                            br.imm;
  wire [23:0]  target     = isRet ? topVal : callTarget;
  wire [23:0]  callRet    = br.delayed ? br.execAddr + bpss_pkg::DELAY_RET
                                       : br.decodeAddr;
  // one push source per cycle; the pipeline never issues two at once
  wire         doPush     = callTaken || loopStartValid || irqEntry;
  wire [23:0]  pushVal    = callTaken ? callRet : loopStartValid ? loopTopAddr : irqRetAddr;
  wire         doPop      = retTaken || loopEnd || abortTaken;

  // ==========================================================
  // pointer next value; a popped overflowed stack stays overflowed
  wire [4:0]   ptrStack   = (doPush && (full || overflowed)) ? bpss_pkg::PTR_OVFL :
                            doPush ? ptr_q + bpss_pkg::PTR_ONE :
                            (doPop && !empty && !overflowed) ? ptr_q - bpss_pkg::PTR_ONE :
                            ptr_q;
  wire [4:0]   ptr_d      = (ptrWrPend_q && !overflowed) ? ptrWr_q : ptrStack;

  // ==========================================================
  // interrupt hold across a delayed branch and its two slots
  wire         delayedNow = brTaken && br.delayed;
  wire         irqBlocked = delayedNow || shadow_q != 2'h0;
  wire         irqFire    = (irqPend_q || irqRequest) && !irqBlocked;
  wire [1:0]   shadow_d   = delayedNow ? bpss_pkg::SHADOW_LEN :
                            (shadow_q != 2'h0) ? shadow_q - 2'h1 : shadow_q;

  // ==========================================================
  // wishbone decode
  wire         wbReq      = wb_cyc_i && wb_stb_i && !ack_q;
  wire         wbWr       = wbReq && wb_we_i && wb_sel_i[0];
  wire         wrPtr      = wbWr && wb_adr_i == bpss_pkg::REG_PTR;
  wire         wrSticky   = wbWr && wb_adr_i == bpss_pkg::REG_STICKY;
  wire         wrMask     = wbWr && wb_adr_i == bpss_pkg::REG_MASK;
  wire [2:0]   ovfSet     = {stacks.statPush && stacks.statFull,
                             stacks.cntPush && stacks.cntFull,
                             stacks.loopPush && stacks.loopFull};
  wire [2:0]   ovfClr     = wrSticky ? wb_dat_i[bpss_pkg::STAT_OVF_B:bpss_pkg::LOOP_OVF_B]
                                     : 3'h0;
  wire [2:0]   ovf_d      = ovfSet | (ovf_q & ~ovfClr); // set wins over clear
  wire [31:0]  stickyView = {26'h0, ovf_q, overflowed, full, empty};
  wire [31:0]  rdat_d     = (wb_adr_i == bpss_pkg::REG_TOP)    ? {8'h0, topVal} :
                            (wb_adr_i == bpss_pkg::REG_PTR)    ? {27'h0, ptr_q} :
                            (wb_adr_i == bpss_pkg::REG_STICKY) ? stickyView :
                            (wb_adr_i == bpss_pkg::REG_MASK)   ? {31'h0, mask_q} : 32'h0;

  // ==========================================================
  // stack storage
  always_ff @(posedge mclk)
  begin
    if (doPush && !full && !overflowed)
      stack_q[ptr_q] <= pushVal;
  end

  // ==========================================================
  // control registers
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      ptr_q       <= bpss_pkg::PTR_EMPTY;
      ptrWr_q     <= bpss_pkg::PTR_EMPTY;
      ptrWrPend_q <= 1'b0;
      shadow_q    <= 2'h0;
      irqPend_q   <= 1'b0;
      ovf_q       <= 3'h0;
      mask_q      <= 1'b0;
    end
    else
    begin
      ptr_q       <= ptr_d;
      ptrWr_q     <= wb_dat_i[bpss_pkg::PTR_W-1:0];
      ptrWrPend_q <= wrPtr;
      shadow_q    <= shadow_d;
      irqPend_q   <= (irqPend_q || irqRequest) && irqBlocked;
      ovf_q       <= ovf_d;
      mask_q      <= wrMask ? wb_dat_i[bpss_pkg::MASK_STK_B] : mask_q;
    end
  end

  // ==========================================================
  // registered pipeline and bus outputs
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      redirect_q     <= 1'b0;
      redirectAddr_q <= '0;
      squash_q       <= 1'b0;
      statusPop_q    <= 1'b0;
      loopPop_q      <= 1'b0;
      loopExit_q     <= 1'b0;
      irqService_q   <= 1'b0;
      ack_q          <= 1'b0;
      rdat_q         <= 32'h0;
    end
    else
    begin
      redirect_q     <= brTaken;
      redirectAddr_q <= brTaken ? target : redirectAddr_q;
      squash_q       <= brTaken && !br.delayed;
      statusPop_q    <= retTaken && br.kind == bpss_pkg::BPSS_RTI && statusFromIrq;
      loopPop_q      <= abortTaken || loopEnd;
      loopExit_q     <= loopEnd;
      irqService_q   <= irqFire;
      ack_q          <= wbReq;
      rdat_q         <= wbReq ? rdat_d : rdat_q;
    end
  end

  assign wb_ack_o     = ack_q;
  assign wb_dat_o     = rdat_q;
  assign redirect     = redirect_q;
  assign redirectAddr = redirectAddr_q;
  assign squashFetch  = squash_q;
  assign squashDecode = squash_q;
  assign statusPop    = statusPop_q;
  assign loopStackPop = loopPop_q;
  assign loopExit     = loopExit_q;
  assign irqService   = irqService_q;
  assign stackIrq     = mask_q && ptr_q == bpss_pkg::STK_ALMOST;
  assign loopOvfIrq   = ovf_q[0];
  assign cntOvfIrq    = ovf_q[1];
  assign statOvfIrq   = ovf_q[2];

  // ==========================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);

  chk_call_push: assert property (callTaken && ptr_q < bpss_pkg::STK_DEPTH
      |=> ptr_q == $past(ptr_q) + 5'h01) else $error("call did not push");
  chk_ret_target: assert property (retTaken |=> redirect && redirectAddr == $past(topVal))
      else $error("return target not stack top");
  chk_nodelay_squash: assert property (brTaken && !br.delayed |=> squashFetch && squashDecode)
      else $error("nondelayed branch not squashed");
  chk_delay_noSquash: assert property (brTaken && br.delayed |=> !squashFetch)
      else $error("delayed branch squashed");
  chk_irq_hold: assert property (delayedNow |=> !irqService [*3])
      else $error("interrupt taken inside delayed window");
  chk_ptr_range: assert property (ptr_q <= bpss_pkg::STK_DEPTH || overflowed)
      else $error("pointer out of range");
  chk_ptr_delay: assert property (wrPtr && !overflowed && !doPush && !doPop ##1 !overflowed
      |=> ptr_q == $past(wb_dat_i[4:0], 2)) else $error("pointer write latency wrong");
  chk_ovfl_hold: assert property (overflowed && !ptrWrPend_q |=> overflowed)
      else $error("overflowed pointer changed");
  chk_full_ovfl: assert property (full && callTaken |=> overflowed)
      else $error("full call did not overflow");
  chk_rti_status: assert property (retTaken && br.kind == bpss_pkg::BPSS_RTS |=> !statusPop)
      else $error("subroutine return popped status");
  chk_cond_false: assert property (br.valid && br.hasCond && br.condCode != bpss_pkg::COND_ALWAYS
      && !condFlags[br.condCode] |=> !redirect) else $error("false condition branched");
  chk_stack_irq: assert property (stackIrq |-> ptr_q == bpss_pkg::STK_ALMOST && mask_q)
      else $error("stack interrupt at wrong depth");

  cov_call_ret: cover property (callTaken ##[1:20] retTaken);
  cov_overflow: cover property (full ##1 callTaken ##1 overflowed);
  // held request fires at the edge after the window, so the pulse shows one cycle later
  cov_irq_held: cover property (delayedNow && irqRequest ##4 irqService);
  cov_loop_abort: cover property (abortTaken);
endmodule : bpss_sequencer

//--- bench/bpss_fetch_model.sv
// fetch-side partner: program counter and the two-slot guard after a delayed branch
// assumes it sees the branch request and the redirect outputs of the sequencer
`timescale 1ns/1ns
module bpss_fetch_model (
  input  wire logic                   mclk,
  input  wire logic                   reset,
  input  wire bpss_pkg::bpss_branch_t br,
  input  wire logic                   redirect,
  input  wire logic [23:0]            redirectAddr,
  output logic      [23:0]            pc_q,
  output logic                        slotFree
);
  // ==========================================================
  // fetch address and delay slots
  logic [1:0] slotCnt_q;
  // no branch may be placed in the two slots after a delayed one
  assign slotFree = (slotCnt_q == 2'h0);
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pc_q      <= 24'h000100;
      slotCnt_q <= 2'h0;
    end
    else
    begin
      pc_q <= redirect ? redirectAddr : pc_q + 24'h000001;
      if (br.valid && br.delayed)
        slotCnt_q <= bpss_pkg::SHADOW_LEN;
      else if (slotCnt_q != 2'h0)
        slotCnt_q <= slotCnt_q - 2'h1;
    end
  end
endmodule : bpss_fetch_model

//--- bench/bpss_sequencer_test.sv
// self-checking bench: queue model of the return stack, wishbone master, branch driver
// assumes bpss_pkg, bpss_sequencer and bpss_fetch_model are compiled before it
`timescale 1ns/1ns
module bpss_sequencer_test;
  // ==========================================================
  // signals
  logic mclk = 1'b0, reset = 1'b1, loopTestValid, inLoop, loopStartValid, statusFromIrq;
  logic irqRequest, irqEntry, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, redirect, slotFree;
  logic squashFetch, squashDecode, statusPop, loopStackPop, loopExit, irqService, stackIrq;
  logic loopOvfIrq, cntOvfIrq, statOvfIrq, ovf, maskOn;
  logic [23:0] dagAddr, loopTopAddr, irqRetAddr, redirectAddr, pc_q;
  logic [30:0] condFlags;
  logic [4:0]  loopCondCode;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, d;
  bpss_pkg::bpss_branch_t br;
  bpss_pkg::bpss_stacks_t stacks;
  logic [23:0] stk[$];
  int          fails = 0, cmp_count = 0, i;
  int unsigned seed;
  always #5 mclk = ~mclk;
  bpss_sequencer dut_u (.mclk, .reset, .br, .dagAddr, .condFlags, .loopTestValid, .loopCondCode,
    .inLoop, .loopStartValid, .loopTopAddr, .statusFromIrq, .irqRequest, .irqEntry, .irqRetAddr,
    .stacks, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
    .wb_ack_o, .redirect, .redirectAddr, .squashFetch, .squashDecode, .statusPop, .loopStackPop,
    .loopExit, .irqService, .stackIrq, .loopOvfIrq, .cntOvfIrq, .statOvfIrq);
  bpss_fetch_model fetch_u (.mclk, .reset, .br, .redirect, .redirectAddr, .pc_q, .slotFree);
  // ==========================================================
  // checking, model and bus tasks
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : report_and_stop
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // a push onto a full stack only marks overflow; nothing is stored
  task automatic mpush(input logic [23:0] a);
    if (stk.size() == 20) ovf = 1'b1;
    else if (!ovf) stk.push_back(a);
  endtask : mpush
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] din,
      output logic [31:0] dout);
    int n;
    @(posedge mclk);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, din};
    n = 0;
    do
    begin
      @(posedge mclk);
      #1;
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (n >= 20) fails++;
    if (n >= 20) report_and_stop();
    @(posedge mclk);
    dout = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  task automatic checkall();
    wb(1'b0, bpss_pkg::REG_PTR, 32'h0, d);
    check("pointer", d, ovf ? 32'h1F : 32'(stk.size()));
    wb(1'b0, bpss_pkg::REG_TOP, 32'h0, d);
    check("top", d, (ovf || stk.size() == 0) ? 32'h0 : 32'(stk[$]));
    wb(1'b0, bpss_pkg::REG_STICKY, 32'h0, d);
    check("sticky", {d[2], d[1] & !ovf, d[0]}, {ovf, stk.size() == 20 && !ovf, stk.size() == 0});
    check("stackIrq", 32'(stackIrq), 32'(maskOn && stk.size() == 19 && !ovf));
  endtask : checkall
  task automatic push_src(input logic irq);
    logic [23:0] a;
    a = 24'($urandom);
    @(posedge mclk);
    {irqEntry, loopStartValid, irqRetAddr, loopTopAddr} <= {irq, !irq, a, a};
    @(posedge mclk);
    {irqEntry, loopStartValid} <= 2'b00;
    mpush(a);
    checkall();
  endtask : push_src
  task automatic loop_test(input logic [4:0] cc);
    logic ex;
    ex = cc != bpss_pkg::COND_ALWAYS && condFlags[cc];
    @(posedge mclk);
    {loopTestValid, loopCondCode} <= {1'b1, cc};
    @(posedge mclk);
    loopTestValid <= 1'b0;
    #1;
    check("loopExit", {loopExit, loopStackPop}, {ex, ex});
    if (ex && !ovf) void'(stk.pop_back());
    checkall();
  endtask : loop_test
  task automatic do_branch(input bpss_pkg::bpss_kind_t k, input bpss_pkg::bpss_src_t s,
      input logic dly, input logic hc, input logic [4:0] cc, input logic la, input logic irq);
    bpss_pkg::bpss_branch_t b;
    logic        tk;
    logic [23:0] tgt;
    int          n;
    b = '0;
    {b.valid, b.kind, b.src, b.hasCond, b.condCode, b.delayed, b.loopAbort} =
      {1'b1, k, s, hc, cc, dly, la};
    b.imm = 24'($urandom);
    b.execAddr = pc_q;
    b.decodeAddr = pc_q + 24'h000001;
    tk = !hc || cc == bpss_pkg::COND_ALWAYS || condFlags[cc];
    tgt = (s == bpss_pkg::BPSS_INDIRECT) ? dagAddr :
          (s == bpss_pkg::BPSS_RELATIVE) ? b.imm + b.execAddr : b.imm;
    if (k[1]) tgt = stk[$];
    for (n = 0; n < 3 && slotFree !== 1'b1; n++) @(posedge mclk);
    @(posedge mclk);
    {br, irqRequest} <= {b, irq};
    @(posedge mclk);
    {br, irqRequest} <= '0;
    #1;
    check("redirect", 32'(redirect), 32'(tk));
    if (tk) check("target", 32'(redirectAddr), 32'(tgt));
    check("squash", {squashFetch, squashDecode}, {2{tk && !dly}});
    check("statusPop", 32'(statusPop), 32'(tk && k == bpss_pkg::BPSS_RTI && statusFromIrq));
    check("loopPop", 32'(loopStackPop), 32'(tk && la && inLoop));
    for (n = 1; n <= (irq ? 4 : 1); n++)
    begin
      if (n > 1) @(posedge mclk);
      if (n > 1) #1;
      check("irqService", 32'(irqService), 32'(irq && n == 4));
    end
    if (tk && k == bpss_pkg::BPSS_CALL) mpush(dly ? b.execAddr + bpss_pkg::DELAY_RET : b.decodeAddr);
    if (tk && !ovf && (k[1] || (la && inLoop))) void'(stk.pop_back());
    checkall();
  endtask : do_branch
  // ==========================================================
  // main sequence
  initial
  begin
    seed = $urandom(34477);
    {br, stacks, dagAddr, condFlags, loopTestValid, loopCondCode, inLoop, loopStartValid} = '0;
    {loopTopAddr, statusFromIrq, irqRequest, irqEntry, irqRetAddr, ovf, maskOn} = '0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} = {43'h0, 4'hF};
    repeat (6) @(posedge mclk);
    {reset, condFlags, dagAddr} <= {1'b0, 31'($urandom) | 31'h1, 24'($urandom)};
    checkall();
    wb(1'b1, bpss_pkg::REG_MASK, 32'h1, d);
    maskOn = 1'b1;
    wb(1'b0, 8'h10, 32'h0, d);
    check("unmapped", d, 32'h0);
    do_branch(bpss_pkg::BPSS_CALL, bpss_pkg::BPSS_DIRECT, 0, 0, 5'h00, 0, 0);
    do_branch(bpss_pkg::BPSS_CALL, bpss_pkg::BPSS_INDIRECT, 1, 0, 5'h00, 0, 0);
    do_branch(bpss_pkg::BPSS_JUMP, bpss_pkg::BPSS_RELATIVE, 1, 0, 5'h00, 0, 1);
    for (i = 0; i < 8; i++) do_branch(bpss_pkg::BPSS_JUMP, bpss_pkg::BPSS_DIRECT, 0, 1, 5'($urandom), 0, 0);
    do_branch(bpss_pkg::BPSS_JUMP, bpss_pkg::BPSS_DIRECT, 0, 1, bpss_pkg::COND_ALWAYS, 0, 0);
    statusFromIrq <= 1'b1;
    do_branch(bpss_pkg::BPSS_RTI, bpss_pkg::BPSS_DIRECT, 0, 0, 5'h00, 0, 0);
    do_branch(bpss_pkg::BPSS_RTS, bpss_pkg::BPSS_DIRECT, 1, 0, 5'h00, 0, 0);
    push_src(1'b0);
    loop_test(bpss_pkg::COND_ALWAYS);
    loop_test(5'h00);
    push_src(1'b0);
    inLoop <= 1'b1;
    do_branch(bpss_pkg::BPSS_JUMP, bpss_pkg::BPSS_DIRECT, 0, 0, 5'h00, 1, 0);
    // second reset in mid-run, then pointer write and a full fill
    reset <= 1'b1;
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    stk.delete();
    maskOn = 1'b0;
    wb(1'b1, bpss_pkg::REG_PTR, 32'h3, d);
    wb(1'b0, bpss_pkg::REG_PTR, 32'h0, d);
    check("ptrWrite", d, 32'h3);
    wb(1'b1, bpss_pkg::REG_PTR, 32'h0, d);
    checkall();
    wb(1'b1, bpss_pkg::REG_MASK, 32'h1, d);
    maskOn = 1'b1;
    for (i = 0; i < 20; i++)
      if (i % 3 == 0) do_branch(bpss_pkg::BPSS_CALL, bpss_pkg::BPSS_DIRECT, 0, 0, 5'h00, 0, 0);
      else push_src(i % 3 == 2);
    do_branch(bpss_pkg::BPSS_CALL, bpss_pkg::BPSS_DIRECT, 0, 0, 5'h00, 0, 0);
    wb(1'b1, bpss_pkg::REG_PTR, 32'h2, d);
    checkall();
    stacks <= '1;
    @(posedge mclk);
    stacks <= '0;
    wb(1'b0, bpss_pkg::REG_STICKY, 32'h0, d);
    check("stackOvf", 32'(d[5:3]), 32'h7);
    check("ovfIrq", {loopOvfIrq, cntOvfIrq, statOvfIrq}, 32'h7);
    wb(1'b1, bpss_pkg::REG_STICKY, 32'h38, d);
    wb(1'b0, bpss_pkg::REG_STICKY, 32'h0, d);
    check("ovfClear", 32'(d[5:3]), 32'h0);
    report_and_stop();
  end
endmodule : bpss_sequencer_test
